// ==== rtl/scss_pkg.sv ====
// shared constants for the system clock select and status block
package scss_pkg;
  // register byte addresses
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STAT_OFS       = 12'h004;
  localparam logic [11:0] TIMER_CTRL_OFS = 12'h008;
  localparam logic [11:0] SRC_OFS        = 12'h00C;
  // control register fields
  localparam int          SCS_LSB        = 0;
  localparam int          IFS_LSB        = 3;
  localparam logic [1:0]  SCS_RST        = 2'h0;
  localparam logic [3:0]  IFS_RST        = 4'h7;
  // status register bits
  localparam int          ST_HFS_BIT     = 0;
  localparam int          ST_LFR_BIT     = 1;
  localparam int          ST_HFR_BIT     = 4;
  localparam int          ST_EXT_BIT     = 5;
  localparam int          ST_SECR_BIT    = 7;
  // timer control: secondary oscillator enable position
  localparam int          SEC_EN_BIT     = 3;
  // stabilisation delays
  localparam int          CLK_MHZ        = 100;
  localparam int          SETTLE_US      = 2;
  localparam int          SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  // active source encoding
  typedef enum logic [1:0] {
    SRC_CFG  = 2'b00,
    SRC_SEC  = 2'b01,
    SRC_INT  = 2'b10
  } scss_src_type;
  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_WAIT  = 2'b01,
    SW_FALL  = 2'b10,
    SW_RISE  = 2'b11
  } scss_sw_type;
  // internal source path selected by a frequency code
  function automatic logic is_lf_code(input logic [3:0] code);
    return code[3:1] == 3'b000;
  endfunction
endpackage

// ==== rtl/scss_sync.sv ====
// three-stage synchroniser with agreement filter for one input
module scss_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic dout_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // change accepted only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      dout_ff <= s3_ff;
    end
  end

  assign dout = dout_ff;
endmodule

// ==== rtl/scss_top.sv ====
// system clock source selection, switch sequencing and status over apb
// Notes on behaviour
// - select 00 runs from the configuration-word clock source.
// - select 01 runs CPU and peripherals from the secondary oscillator.
// - select 1x runs from the internal block at the chosen frequency.
// - any reset clears the select field.
// - after a source change the new clock waits a stabilisation delay, unless the same internal oscillator stays in use.
// - external-running bit is 1 on external input, 0 on internal.
// - external-running bit ignores the secondary oscillator entirely.
// - secondary oscillator runs only while its enable bit is set.
// - secondary ready reports oscillator readiness; reads 1 when disabled.
// - frequency code decode; resets to 0111 (500 kHz).
// - codes 1000 to 1010 derive from the high-frequency oscillator.
// - control: frequency bits 6..3, select bits 1..0, bits 7 and 2 zero.
// - status bit 4 shows high-frequency oscillator ready.
// - status bit 1 shows low-frequency oscillator ready.
// - status bit 0 shows 16 MHz oscillator stable, whichever source is active.
// - status: secondary ready bit 7, external bit 5, 6/3/2 zero.
// - switch waits old clock falling, holds low, then new rising.
// - change within the same internal oscillator has no start-up delay.
// - low oscillator ~31 kHz uncalibrated; high 16 MHz calibrated.
module scss_top #(
  parameter int SETTLE_CYCLES = scss_pkg::SETTLE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  config_clock_source,
  input  wire logic        hf_osc_ready,
  input  wire logic        hf_osc_stable,
  input  wire logic        lf_osc_ready,
  input  wire logic        secondary_osc_ready,
  input  wire logic        old_clk_level,
  input  wire logic        new_clk_level,
  output logic [1:0]       active_source,
  output logic [3:0]       active_freq_select,
  output logic             clock_gate_low,
  output logic             secondary_osc_enable,
  output logic             hf_osc_enable,
  output logic             lf_osc_enable,
  output logic             switch_busy
);
  // settle counter is 16 bits and needs at least one cycle
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  logic [1:0]  sys_clk_sel_ff;
  logic [3:0]  int_freq_sel_ff;
  logic        sec_en_ff;
  logic [1:0]  cfg_src_ff;
  logic        cfg_taken_ff;
  logic [1:0]  act_src_ff;
  logic [3:0]  act_freq_ff;
  logic        gate_low_ff;
  logic        busy_ff;
  logic [15:0] settle_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        hf_en_ff;
  logic        lf_en_ff;
  scss_pkg::scss_sw_type sw_ff;

  logic hf_rdy_s;
  logic hf_stb_s;
  logic lf_rdy_s;
  logic sec_rdy_s;
  logic old_clk_s;
  logic new_clk_s;

  scss_sync u_hfr (.pclk(pclk), .presetn(presetn),
                   .din(hf_osc_ready), .dout(hf_rdy_s));
  scss_sync u_hfs (.pclk(pclk), .presetn(presetn),
                   .din(hf_osc_stable), .dout(hf_stb_s));
  scss_sync u_lfr (.pclk(pclk), .presetn(presetn),
                   .din(lf_osc_ready), .dout(lf_rdy_s));
  scss_sync u_scr (.pclk(pclk), .presetn(presetn),
                   .din(secondary_osc_ready), .dout(sec_rdy_s));
  scss_sync u_old (.pclk(pclk), .presetn(presetn),
                   .din(old_clk_level), .dout(old_clk_s));
  scss_sync u_new (.pclk(pclk), .presetn(presetn),
                   .din(new_clk_level), .dout(new_clk_s));

  // apb: zero wait state, single-cycle access phase
  logic acc;
  logic wr;
  // write lands only on the access edge that sees pready high
  assign acc = psel && penable && pready_ff;
  assign wr  = acc && pwrite;

  // strap captured on the first clock after release, never by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_src_ff   <= 2'h0;
      cfg_taken_ff <= 1'b0;
    end else if (!cfg_taken_ff) begin
      cfg_src_ff   <= config_clock_source;
      cfg_taken_ff <= 1'b1;
    end
  end

  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_sel_ff  <= scss_pkg::SCS_RST;
      int_freq_sel_ff <= scss_pkg::IFS_RST;
    end else if (wr && paddr == scss_pkg::CTRL_OFS) begin
      sys_clk_sel_ff  <= pwdata[scss_pkg::SCS_LSB +: 2];
      int_freq_sel_ff <= pwdata[scss_pkg::IFS_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_en_ff <= 1'b0;
    end else if (wr && paddr == scss_pkg::TIMER_CTRL_OFS) begin
      sec_en_ff <= pwdata[scss_pkg::SEC_EN_BIT];
    end
  end

  // requested source from the select field
  logic [1:0] req_src;
  always_comb begin
    if (sys_clk_sel_ff[1])
      req_src = scss_pkg::SRC_INT;
    else if (sys_clk_sel_ff[0])
      req_src = scss_pkg::SRC_SEC;
    else
      req_src = scss_pkg::SRC_CFG;
  end

  // config source 00 means internal block, others external input
  logic cfg_internal;
  assign cfg_internal = (cfg_src_ff == 2'b00);

  // does the requested setting need the low-frequency path?
  logic req_uses_lf;
  logic req_uses_int;
  assign req_uses_int = (req_src == scss_pkg::SRC_INT) ||
                        (req_src == scss_pkg::SRC_CFG && cfg_internal);
  assign req_uses_lf  = scss_pkg::is_lf_code(int_freq_sel_ff);

  logic act_uses_lf;
  logic act_uses_int;
  assign act_uses_int = (act_src_ff == scss_pkg::SRC_INT) ||
                        (act_src_ff == scss_pkg::SRC_CFG && cfg_internal);
  assign act_uses_lf  = scss_pkg::is_lf_code(act_freq_ff);

  logic change;
  logic same_osc;
  assign change   = (req_src != act_src_ff) ||
                    (req_uses_int && int_freq_sel_ff != act_freq_ff);
  assign same_osc = req_uses_int && act_uses_int &&
                    (req_uses_lf == act_uses_lf);

  // oscillator enables: each path runs while requested or active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_en_ff <= 1'b0;
      lf_en_ff <= 1'b0;
    end else begin
      hf_en_ff <= (req_uses_int && !req_uses_lf) ||
                  (act_uses_int && !act_uses_lf);
      lf_en_ff <= (req_uses_int && req_uses_lf) ||
                  (act_uses_int && act_uses_lf);
    end
  end

  // switch sequencer: settle, old clock falls, held low, new clock rises
  logic [15:0] settle_init;
  assign settle_init = same_osc ? 16'h0000 : 16'(SETTLE_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ff       <= scss_pkg::SW_IDLE;
      settle_ff   <= 16'h0000;
      act_src_ff  <= scss_pkg::SRC_CFG;
      act_freq_ff <= scss_pkg::IFS_RST;
      gate_low_ff <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      case (sw_ff)
        scss_pkg::SW_IDLE: begin
          if (change && cfg_taken_ff) begin
            settle_ff <= settle_init;
            busy_ff   <= 1'b1;
            sw_ff     <= scss_pkg::SW_WAIT;
          end
        end
        scss_pkg::SW_WAIT: begin
          if (settle_ff != 16'h0000)
            settle_ff <= settle_ff - 16'h0001;
          else if (!old_clk_s) begin
            gate_low_ff <= 1'b1;
            sw_ff       <= scss_pkg::SW_FALL;
          end
        end
        scss_pkg::SW_FALL: begin
          // wait for new clock low so its next rise is a true edge
          if (!new_clk_s)
            sw_ff <= scss_pkg::SW_RISE;
        end
        scss_pkg::SW_RISE: begin
          if (new_clk_s) begin
            act_src_ff  <= req_src;
            act_freq_ff <= int_freq_sel_ff;
            gate_low_ff <= 1'b0;
            busy_ff     <= 1'b0;
            sw_ff       <= scss_pkg::SW_IDLE;
          end
        end
        default: sw_ff <= scss_pkg::SW_IDLE;
      endcase
    end
  end

  // status composition
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[scss_pkg::ST_SECR_BIT] = sec_en_ff ? sec_rdy_s : 1'b1;
    // external only when config source active and external
    status[scss_pkg::ST_EXT_BIT] = (act_src_ff == scss_pkg::SRC_CFG) &&
                                   !cfg_internal;
    status[scss_pkg::ST_HFR_BIT] = hf_rdy_s;
    status[scss_pkg::ST_LFR_BIT] = lf_rdy_s;
    status[scss_pkg::ST_HFS_BIT] = hf_stb_s;
  end

  // apb read path and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == scss_pkg::CTRL_OFS)
          prdata_ff <= {25'h0, int_freq_sel_ff, 1'b0,
                        sys_clk_sel_ff};
        else if (paddr == scss_pkg::STAT_OFS)
          prdata_ff <= {24'h0, status};
        else if (paddr == scss_pkg::TIMER_CTRL_OFS)
          prdata_ff <= {28'h0, sec_en_ff, 3'h0};
        else if (paddr == scss_pkg::SRC_OFS)
          prdata_ff <= {29'h0, busy_ff, act_src_ff};
        else
          pslverr_ff <= 1'b1;
      end
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign active_source        = act_src_ff;
  assign active_freq_select   = act_freq_ff;
  assign clock_gate_low       = gate_low_ff;
  assign secondary_osc_enable = sec_en_ff;
  assign hf_osc_enable        = hf_en_ff;
  assign lf_osc_enable        = lf_en_ff;
  assign switch_busy          = busy_ff;

  a_reset_select: assert property (@(posedge pclk)
    $rose(presetn) |-> sys_clk_sel_ff == 2'b00 && int_freq_sel_ff == 4'h7)
    else $error("select or frequency not at reset value");
  a_sec_ready_dis: assert property (@(posedge pclk)
    disable iff (!presetn) !sec_en_ff |-> status[7])
    else $error("secondary ready low while disabled");
  a_ext_running: assert property (@(posedge pclk)
    disable iff (!presetn) act_src_ff == scss_pkg::SRC_SEC |-> !status[5])
    else $error("external bit set on secondary source");
  a_ctrl_zero: assert property (@(posedge pclk)
    disable iff (!presetn) pready && paddr == scss_pkg::CTRL_OFS
    |-> !prdata[7] && !prdata[2])
    else $error("control register unused bits not zero");
  a_gate_until: assert property (@(posedge pclk)
    disable iff (!presetn) gate_low_ff ==
    (sw_ff == scss_pkg::SW_FALL || sw_ff == scss_pkg::SW_RISE))
    else $error("gate low outside the switch hold window");
  a_switch_commit: assert property (@(posedge pclk)
    disable iff (!presetn)
    $changed(act_src_ff) |-> $past(sw_ff) == scss_pkg::SW_RISE)
    else $error("source changed outside switch sequence");
  a_same_osc_fast: assert property (@(posedge pclk)
    disable iff (!presetn)
    sw_ff == scss_pkg::SW_IDLE && change && same_osc && cfg_taken_ff
    |=> settle_ff == 16'h0000)
    else $error("start-up delay on same-oscillator change");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_status_hf: assert property (@(posedge pclk)
    disable iff (!presetn) status[4] == hf_rdy_s && status[1] == lf_rdy_s)
    else $error("oscillator ready bits misplaced");
  c_switch_done: cover property (@(posedge pclk) disable iff (!presetn)
    sw_ff == scss_pkg::SW_RISE ##1 sw_ff == scss_pkg::SW_IDLE);
  c_go_int: cover property (@(posedge pclk) disable iff (!presetn)
    $changed(act_src_ff) && act_src_ff == scss_pkg::SRC_INT);
  c_go_sec: cover property (@(posedge pclk) disable iff (!presetn)
    $changed(act_src_ff) && act_src_ff == scss_pkg::SRC_SEC);
endmodule

// ==== sim/scss_osc_model.sv ====
// oscillator sources model: ready and stable levels plus clock phases
module scss_osc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic hf_osc_enable,
  input  wire logic lf_osc_enable,
  input  wire logic secondary_osc_enable,
  output logic      hf_osc_ready,
  output logic      hf_osc_stable,
  output logic      lf_osc_ready,
  output logic      secondary_osc_ready,
  output logic      old_clk_level,
  output logic      new_clk_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] hf_ff, lf_ff, sec_ff, lim;
  logic [3:0] ph_ff;
  // slow start stretches every oscillator start-up
  assign lim = slow ? 6'h28 : 6'h08;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_ff  <= 6'h00;
      lf_ff  <= 6'h00;
      sec_ff <= 6'h00;
      ph_ff  <= 4'h0;
    end else begin
      ph_ff  <= ph_ff + 4'h1;
      hf_ff  <= !hf_osc_enable ? 6'h00 : (hf_ff > lim) ? hf_ff : hf_ff + 6'h01;
      lf_ff  <= !lf_osc_enable ? 6'h00 : (lf_ff > lim) ? lf_ff : lf_ff + 6'h01;
      sec_ff <= !secondary_osc_enable ? 6'h00 :
                (sec_ff > lim) ? sec_ff : sec_ff + 6'h01;
    end
  end
  assign hf_osc_ready        = hf_ff >= lim;
  assign hf_osc_stable       = hf_ff > lim;
  assign lf_osc_ready        = lf_ff >= lim;
  // crystal only oscillates while enabled
  assign secondary_osc_ready = sec_ff >= lim;
  assign old_clk_level       = ph_ff[1];
  assign new_clk_level       = ph_ff[2];
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the clock select and status block
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er;
  logic        gate_seen = 1'b0;
  logic [1:0]  config_clock_source, active_source;
  logic [3:0]  active_freq_select;
  logic        clock_gate_low, secondary_osc_enable, hf_osc_enable;
  logic        lf_osc_enable, switch_busy, hf_r, hf_s, lf_r, sec_r;
  logic        old_l, new_l;
  int          num_errors, tests_run, cyc;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d, m, e;
    logic        err;
  } scss_row_type;
  scss_row_type rows[5] = '{
    '{12'h000, 32'h000000FF, 32'h000000FF, 32'h0000007B, 1'b0},
    '{12'h00C, 32'h00000000, 32'h00000007, 32'h00000002, 1'b0},
    '{12'h000, 32'h00000004, 32'h000000FF, 32'h00000000, 1'b0},
    '{12'h010, 32'h00000055, 32'hFFFFFFFF, 32'h00000000, 1'b1},
    '{12'h008, 32'h00000000, 32'h00000008, 32'h00000000, 1'b0}};
  scss_top #(.SETTLE_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_clock_source(config_clock_source), .hf_osc_ready(hf_r),
    .hf_osc_stable(hf_s), .lf_osc_ready(lf_r), .secondary_osc_ready(sec_r),
    .old_clk_level(old_l), .new_clk_level(new_l),
    .active_source(active_source), .active_freq_select(active_freq_select),
    .clock_gate_low(clock_gate_low),
    .secondary_osc_enable(secondary_osc_enable),
    .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable),
    .switch_busy(switch_busy));
  scss_osc_model i_osc (.pclk(pclk), .presetn(presetn), .slow(slow),
    .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable),
    .secondary_osc_enable(secondary_osc_enable), .hf_osc_ready(hf_r),
    .hf_osc_stable(hf_s), .lf_osc_ready(lf_r),
    .secondary_osc_ready(sec_r), .old_clk_level(old_l),
    .new_clk_level(new_l));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (clock_gate_low === 1'b1)
      gate_seen <= 1'b1;
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 400 && switch_busy !== 1'b0; i++)
      @(posedge pclk);
    repeat (12) @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic chk_stat(input logic ext);
    apb(12'h004, 1'b0, 32'h0);
    // secondary ready follows the crystal only while it is enabled
    `CHK(rd[7], secondary_osc_enable ? sec_r : 1'b1)
    `CHK({rd[6], rd[3], rd[2]}, 3'h0)
    `CHK(rd[5], ext)
    `CHK(rd[4], hf_r)
    `CHK(rd[1], lf_r)
    `CHK(rd[0], hf_s)
  endtask
  initial begin
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    config_clock_source = 2'h1;
    presetn = 1'b0;
    do_reset();
    apb(12'h000, 1'b0, 32'h0);
    `CHK(rd, 32'h00000038)
    `CHK(active_source, 2'h0)
    repeat (60) @(posedge pclk);
    chk_stat(1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      `CHK(rd & rows[i].m, rows[i].e)
      `CHK(er, rows[i].err)
      wait_idle();
    end
    $display("register rows done");
    for (int c = 0; c < 16; c++) begin
      apb(12'h000, 1'b1, 32'(c << 3) | 32'h2);
      wait_idle();
      `CHK(active_freq_select, 4'(c))
      `CHK(active_source, 2'h2)
      if (c > 1)
        `CHK(hf_osc_enable, 1'b1)
      else
        `CHK(lf_osc_enable, 1'b1)
      `CHK(switch_busy, 1'b0)
    end
    `CHK(gate_seen, 1'b1)
    repeat (60) @(posedge pclk);
    chk_stat(1'b0);
    $display("frequency codes done");
    slow <= 1'b1;
    apb(12'h008, 1'b1, 32'h00000008);
    @(posedge pclk);
    `CHK(secondary_osc_enable, 1'b1)
    // software waits for the crystal before selecting it
    for (int i = 0; i < 100; i++) begin
      apb(12'h004, 1'b0, 32'h0);
      if (rd[7] === 1'b1)
        break;
    end
    `CHK(rd[7], 1'b1)
    apb(12'h000, 1'b1, 32'h00000039);
    wait_idle();
    `CHK(active_source, 2'h1)
    chk_stat(1'b0);
    apb(12'h008, 1'b1, 32'h0);
    @(posedge pclk);
    `CHK(secondary_osc_enable, 1'b0)
    $display("secondary test done");
    config_clock_source <= 2'h0;
    do_reset();
    apb(12'h000, 1'b0, 32'h0);
    `CHK(rd, 32'h00000038)
    `CHK(active_source, 2'h0)
    // strap moves after release; the latched copy must not follow it
    config_clock_source <= 2'h3;
    repeat (60) @(posedge pclk);
    chk_stat(1'b0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
